// >>> hw/uplp_params.svh
// Purpose: address map, field positions and codes of the parallel link port
// Assumes: APB with 12-bit byte addresses
// Notes: definitions only
`ifndef UPLP_PARAMS_SVH
`define UPLP_PARAMS_SVH
// ==========================================
// register map
`define UPLP_ADDR_CTRL 12'h000
`define UPLP_ADDR_STATUS 12'h004
`define UPLP_ADDR_TXPOP 12'h008
`define UPLP_ADDR_RXDATA 12'h00c
// ==========================================
// fields
`define UPLP_CTRL_SUSPEND 0
`define UPLP_CTRL_HOST 1
`define UPLP_CTRL_RXACT 2
`define UPLP_ST_DISC 3
`define UPLP_TXPOP_VALID 31
// ==========================================
// codes
`define UPLP_SPEED_HS 2'h0
`define UPLP_MODE_NORMAL 2'h0
`define UPLP_MODE_NONDRV 2'h1
`define UPLP_MODE_RAW 2'h2
`define UPLP_MODE_RSVD 2'h3
`define UPLP_KIND_DATA 2'h0
`define UPLP_KIND_SYNC 2'h1
`define UPLP_KIND_EOP 2'h2
`define UPLP_TX_HOLDOFF 2'h3
`endif

// >>> hw/uplp_pkg.sv
// Purpose: types of the parallel link port
// Assumes: nothing
// Notes: constants live in uplp_params.svh
package uplp_pkg;
	typedef enum logic [1:0] {tx_idle, tx_sync, tx_data, tx_eop} uplp_tx_state_t;
endpackage : uplp_pkg

// >>> hw/uplp_port.sv
// Purpose: link-side parallel port of a usb transceiver, apb view of the line side
// Assumes: link pins are asynchronous to pclk and pass two flip-flops
// Notes: apb software stands in for the serial engine
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "uplp_params.svh"

// ==========================================
// fifo
module uplp_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic push, pop;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
			$error("uplp_fifo depth must be a power of two");
		end
	endgenerate

	assign in_ready = (wr_reg - rd_reg) != (AW + 1)'(DEPTH);
	assign out_valid = wr_reg != rd_reg;
	assign out_data = mem[rd_reg[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// storage has no reset; only pointers need one
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end
endmodule : uplp_fifo

// ==========================================
// top
module uplp_port #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic reference_clock_out,
	input wire logic [1:0] speed_select,
	input wire logic [1:0] operating_mode_select,
	input wire logic transmit_valid,
	output logic transmit_ready,
	output logic receive_valid,
	output logic receive_in_progress,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	output logic [1:0] bus_line_state,
	output logic host_disconnect_flag,
	output logic termination_enable,
	input wire logic positive_data_line,
	input wire logic negative_data_line,
	input wire logic disconnect_envelope
);
	logic [15:0] sync1_reg, sync2_reg;
	logic tv_s, pos_s, neg_s, env_s;
	logic [7:0] din_s;
	logic [1:0] speed_s, mode_s;
	logic ref_reg, ref_next;
	logic [2:0] ctrl_reg, ctrl_next;
	logic susp_d_reg, susp_d_next, lp_entry;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic pop_pend_reg, pop_pend_next;
	logic setup, acc, wr_acc, mapped, drive_ok, raw;
	logic [1:0] ls_stage_reg, ls_stage_next, ls_reg, ls_next;
	logic disc_reg, disc_next, disc_set, disc_clr;
	uplp_pkg::uplp_tx_state_t st_reg, st_next;
	logic [1:0] hold_reg, hold_next;
	logic take, push;
	logic [1:0] kind;
	logic txr_reg, txr_next;
	logic rxv_reg, rxv_next, rxa_reg, rxa_next, oe_n_reg, oe_n_next, term_reg, term_next;
	logic [7:0] dout_reg, dout_next;
	logic rx_wr;
	logic fifo_in_ready, fifo_out_valid;
	logic [9:0] fifo_out_data;

	generate
		if (FIFO_DEPTH < 2) begin : g_bad
			$error("uplp_port fifo depth too small");
		end
	endgenerate

	// ==========================================
	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {transmit_valid, data_in, speed_select, operating_mode_select,
				positive_data_line, negative_data_line, disconnect_envelope};
			sync2_reg <= sync1_reg;
		end
	end
	assign {tv_s, din_s, speed_s, mode_s, pos_s, neg_s, env_s} = sync2_reg;

	// reserved mode is handled like non-driving, never as normal
	assign drive_ok = (mode_s == `UPLP_MODE_NORMAL || mode_s == `UPLP_MODE_RAW)
		&& !ctrl_reg[`UPLP_CTRL_SUSPEND];
	assign raw = mode_s == `UPLP_MODE_RAW;
	assign lp_entry = ctrl_reg[`UPLP_CTRL_SUSPEND] && !susp_d_reg;

	// ==========================================
	// apb slave, zero wait states
	assign setup = psel && !penable;
	assign acc = psel && penable && pready_reg;
	assign wr_acc = acc && pwrite;
	assign mapped = paddr == `UPLP_ADDR_CTRL || paddr == `UPLP_ADDR_STATUS
		|| paddr == `UPLP_ADDR_TXPOP || paddr == `UPLP_ADDR_RXDATA;
	assign rx_wr = wr_acc && paddr == `UPLP_ADDR_RXDATA && rxa_reg && drive_ok;

	always_comb begin
		pready_next = setup;
		pslverr_next = setup && !mapped;
		pop_pend_next = setup && !pwrite && paddr == `UPLP_ADDR_TXPOP && fifo_out_valid;
		prdata_next = '0;
		if (setup && !pwrite) begin
			case (paddr)
				`UPLP_ADDR_CTRL: prdata_next = {29'h0, ctrl_reg};
				`UPLP_ADDR_STATUS: prdata_next = {21'h0, !fifo_in_ready, !fifo_out_valid,
					mode_s == `UPLP_MODE_RSVD, mode_s, speed_s, disc_reg, rxa_reg, ls_reg};
				`UPLP_ADDR_TXPOP: prdata_next = {fifo_out_valid, 21'h0, fifo_out_data};
				default: prdata_next = '0;
			endcase
		end
		ctrl_next = ctrl_reg;
		if (wr_acc && paddr == `UPLP_ADDR_CTRL) begin
			ctrl_next = pwdata[2:0];
		end
		susp_d_next = ctrl_reg[`UPLP_CTRL_SUSPEND];
		ref_next = !ref_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			pop_pend_reg <= 1'b0;
			prdata_reg <= '0;
			ctrl_reg <= '0;
			susp_d_reg <= 1'b0;
			ref_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			pop_pend_reg <= pop_pend_next;
			prdata_reg <= prdata_next;
			ctrl_reg <= ctrl_next;
			susp_d_reg <= susp_d_next;
			ref_reg <= ref_next;
		end
	end

	// ==========================================
	// line state and host disconnect
	assign disc_set = ctrl_reg[`UPLP_CTRL_HOST] && speed_s == `UPLP_SPEED_HS && env_s
		&& !ctrl_reg[`UPLP_CTRL_SUSPEND];
	assign disc_clr = wr_acc && paddr == `UPLP_ADDR_STATUS && pwdata[`UPLP_ST_DISC];

	always_comb begin
		ls_stage_next = {neg_s, pos_s};
		// suspended: skip the stage, the closest to combinational a flopped output gets
		ls_next = ctrl_reg[`UPLP_CTRL_SUSPEND] ? {neg_s, pos_s} : ls_stage_reg;
		disc_next = disc_reg;
		if (lp_entry) begin
			disc_next = 1'b0;
		end else if (disc_set) begin
			disc_next = 1'b1;
		end else if (disc_clr) begin
			disc_next = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_stage_reg <= '0;
			ls_reg <= '0;
			disc_reg <= 1'b0;
		end else begin
			ls_stage_reg <= ls_stage_next;
			ls_reg <= ls_next;
			disc_reg <= disc_next;
		end
	end

	// ==========================================
	// transmit path into the fifo
	always_comb begin
		st_next = st_reg;
		hold_next = hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0;
		take = 1'b0;
		push = 1'b0;
		kind = `UPLP_KIND_DATA;
		case (st_reg)
			uplp_pkg::tx_idle: begin
				if (tv_s && drive_ok) begin
					st_next = raw ? uplp_pkg::tx_data : uplp_pkg::tx_sync;
				end
			end
			uplp_pkg::tx_sync: begin
				kind = `UPLP_KIND_SYNC;
				push = fifo_in_ready;
				if (fifo_in_ready) begin
					st_next = uplp_pkg::tx_data;
				end
			end
			uplp_pkg::tx_data: begin
				if (!tv_s) begin
					st_next = raw ? uplp_pkg::tx_idle : uplp_pkg::tx_eop;
				end else if (hold_reg == 2'h0 && fifo_in_ready) begin
					// holdoff lets the link's next byte cross the synchroniser
					take = 1'b1;
					push = 1'b1;
					hold_next = `UPLP_TX_HOLDOFF;
				end
			end
			uplp_pkg::tx_eop: begin
				kind = `UPLP_KIND_EOP;
				push = fifo_in_ready;
				if (fifo_in_ready) begin
					st_next = uplp_pkg::tx_idle;
				end
			end
			default: st_next = uplp_pkg::tx_idle;
		endcase
		txr_next = take;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= uplp_pkg::tx_idle;
			hold_reg <= 2'h0;
			txr_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			hold_reg <= hold_next;
			txr_reg <= txr_next;
		end
	end

	uplp_fifo #(
		.WIDTH(10),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({kind, din_s}),
		.out_valid(fifo_out_valid),
		.out_ready(acc && pop_pend_reg),
		.out_data(fifo_out_data)
	);

	// ==========================================
	// receive path onto the shared bus
	always_comb begin
		rxa_next = ctrl_reg[`UPLP_CTRL_RXACT] && drive_ok;
		rxv_next = rx_wr;
		dout_next = rx_wr ? pwdata[7:0] : dout_reg;
		oe_n_next = !(rxa_reg && drive_ok && !tv_s);
		term_next = mode_s != `UPLP_MODE_NONDRV && mode_s != `UPLP_MODE_RSVD;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxa_reg <= 1'b0;
			rxv_reg <= 1'b0;
			dout_reg <= '0;
			oe_n_reg <= 1'b1;
			term_reg <= 1'b0;
		end else begin
			rxa_reg <= rxa_next;
			rxv_reg <= rxv_next;
			dout_reg <= dout_next;
			oe_n_reg <= oe_n_next;
			term_reg <= term_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign reference_clock_out = ref_reg;
	assign transmit_ready = txr_reg;
	assign receive_valid = rxv_reg;
	assign receive_in_progress = rxa_reg;
	assign data_out = dout_reg;
	assign data_oe_n = oe_n_reg;
	assign bus_line_state = ls_reg;
	assign host_disconnect_flag = disc_reg;
	assign termination_enable = term_reg;

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence tx_start_s;
		st_reg == uplp_pkg::tx_idle && tv_s && drive_ok && !raw;
	endsequence
	sequence tx_take_s;
		st_reg == uplp_pkg::tx_data && tv_s && hold_reg == 2'h0 && fifo_in_ready;
	endsequence

	chk_nondrive_off: assert property ((mode_s == `UPLP_MODE_NONDRV) |=> data_oe_n && !termination_enable)
		else $error("non-driving mode still drives");
	chk_raw_no_frame: assert property ((push && raw) |-> kind == `UPLP_KIND_DATA)
		else $error("raw mode framed a packet");
	chk_sync_first: assert property (tx_start_s |=> st_reg == uplp_pkg::tx_sync)
		else $error("sync not started");
	chk_ready_pulse: assert property (tx_take_s |=> transmit_ready ##1 !transmit_ready)
		else $error("transmit ready not one pulse");
	chk_ls_registered: assert property (!ctrl_reg[`UPLP_CTRL_SUSPEND]
		|=> bus_line_state == $past(ls_stage_reg))
		else $error("line state not via stage");
	chk_ls_suspend: assert property (ctrl_reg[`UPLP_CTRL_SUSPEND] |=> bus_line_state == $past({neg_s, pos_s}))
		else $error("line state not direct in suspend");
	chk_disc_raise: assert property ((disc_set && !lp_entry) |=> host_disconnect_flag)
		else $error("disconnect not raised");
	chk_disc_lowpower: assert property (lp_entry |=> !host_disconnect_flag)
		else $error("disconnect kept in low power");
	chk_rx_byte: assert property (rx_wr |=> receive_valid && data_out == $past(pwdata[7:0]) ##1 !receive_valid)
		else $error("receive byte not presented");
	chk_rx_active: assert property ((ctrl_reg[`UPLP_CTRL_RXACT] && drive_ok) |=> receive_in_progress)
		else $error("receive active missing");
endmodule : uplp_port

// >>> tb/uplp_link_model.sv
// Purpose: link controller model beside the port's parallel pins
// Assumes: the bench resolves the shared data wire and feeds it here
// Notes: each byte is held until transmit_ready is seen
`timescale 1ns/1ps
module uplp_link_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic transmit_ready,
	input wire logic receive_valid,
	input wire logic [7:0] bus,
	output logic transmit_valid,
	output logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_seen
);
	logic [7:0] q[$];
	int edges;
	initial begin
		transmit_valid = 1'b0;
		tx_byte = 8'h00;
		rx_byte = 8'h00;
		rx_seen = 1'b0;
		edges = 0;
	end
	// ==========================================
	// transmit and receive, both on the port clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edges <= 0;
			transmit_valid <= 1'b0;
		end else if (edges < 5) begin
			edges <= edges + 1;
		end else if (transmit_valid && transmit_ready) begin
			void'(q.pop_front());
			if (q.size() == 0) transmit_valid <= 1'b0;
			else tx_byte <= q[0];
		end else if (!transmit_valid && q.size() > 0) begin
			transmit_valid <= 1'b1;
			tx_byte <= q[0];
		end
		if (presetn && receive_valid) begin
			rx_byte <= bus;
			rx_seen <= 1'b1;
		end
	end
endmodule : uplp_link_model

// >>> tb/usb_phy_parallel_link_port_tb.sv
// Purpose: self-checking bench of the parallel link port
// Assumes: apb answers with no wait states but is awaited anyway
// Notes: data wire has a pull-low when nobody drives
`timescale 1ns/1ps
module usb_phy_parallel_link_port_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, refclk, tr, rv, rip, oe_n, hdf, term, tv, rxs;
	logic [1:0] spd = 2'h0, mode = 2'h0, ls;
	logic pos_l = 0, neg_l = 0, env = 0;
	logic [7:0] dout, txb, rxb, bus;
	int err_total = 0, n_checks = 0;
	// pull-low wins only when both ends are released
	assign bus = !oe_n ? dout : (tv ? txb : 8'h00);
	always #25 pclk = ~pclk;
	uplp_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reference_clock_out(refclk), .speed_select(spd), .operating_mode_select(mode),
		.transmit_valid(tv), .transmit_ready(tr), .receive_valid(rv), .receive_in_progress(rip),
		.data_in(bus), .data_out(dout), .data_oe_n(oe_n), .bus_line_state(ls),
		.host_disconnect_flag(hdf), .termination_enable(term), .positive_data_line(pos_l),
		.negative_data_line(neg_l), .disconnect_envelope(env));
	uplp_link_model link (.pclk(pclk), .presetn(presetn), .transmit_ready(tr), .receive_valid(rv),
		.bus(bus), .transmit_valid(tv), .tx_byte(txb), .rx_byte(rxb), .rx_seen(rxs));
	// ==========================================
	// tasks
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic lat(input logic [1:0] v, output int c);
		@(posedge pclk);
		{neg_l, pos_l} <= v;
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (ls !== v && c < 10);
	endtask : lat
	// raw mode frames nothing: no sync or eop marker
	task automatic txrun(input int n, input logic [1:0] m);
		int k, r, kd, tot, off;
		mode <= m;
		off = (m == 2'h2) ? 0 : 1;
		tot = n + 2 * off;
		// mode settles before transmit-valid rises
		repeat (4) @(posedge pclk);
		for (k = 0; k < n; k++) link.q.push_back(8'h10 + k);
		repeat (200) @(posedge pclk);
		apb(0, 12'h004, 0);
		chk(rd[10], n >= 16);
		for (k = 0; k < tot; k++) begin
			r = 0;
			do begin
				apb(0, 12'h008, 0);
				r++;
			end while (rd[31] !== 1'b1 && r < 50);
			chk(rd[31], 1);
			kd = (off == 1 && k == 0) ? 1 : ((off == 1 && k == n + 1) ? 2 : 0);
			chk(rd[9:8], kd);
			if (kd == 0) chk(rd[7:0], 8'h10 + k - off);
		end
		repeat (20) @(posedge pclk);
		apb(0, 12'h008, 0);
		chk(rd[31], 0);
		$display("tx mode %0d done, checks=%0d", m, n_checks);
	endtask : txrun
	// ==========================================
	// tests
	initial begin
		int i, c1, c2;
		logic a;
		repeat (8) @(posedge pclk);
		chk(oe_n, 1);
		presetn <= 1'b1;
		apb(0, 12'h000, 0);
		chk(rd, 0);
		apb(0, 12'h010, 0);
		chk(se, 1);
		@(posedge pclk);
		a = refclk;
		@(posedge pclk);
		chk(refclk, !a);
		$display("reset done");
		for (i = 0; i < 4; i++) begin
			spd <= i;
			mode <= i;
			repeat (4) @(posedge pclk);
			apb(0, 12'h004, 0);
			chk(rd[5:4], i);
			chk(rd[7:6], i);
			chk(rd[8], i == 3);
		end
		spd <= 2'h0;
		mode <= 2'h0;
		for (i = 0; i < 4; i++) begin
			{neg_l, pos_l} <= i;
			repeat (5) @(posedge pclk);
			chk(ls, i);
			apb(0, 12'h004, 0);
			chk(rd[1:0], i);
		end
		lat(2'h1, c1);
		apb(1, 12'h000, 32'h1);
		lat(2'h2, c2);
		chk(c1 - c2, 1);
		apb(1, 12'h000, 32'h2);
		$display("line state done");
		env <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(hdf, 1);
		apb(0, 12'h004, 0);
		chk(rd[3], 1);
		env <= 1'b0;
		apb(1, 12'h000, 32'h3);
		repeat (3) @(posedge pclk);
		chk(hdf, 0);
		$display("disconnect done");
		apb(1, 12'h000, 32'h4);
		repeat (4) @(posedge pclk);
		chk(oe_n, 0);
		chk(term, 1);
		chk(rip, 1);
		apb(0, 12'h004, 0);
		chk(rd[2], 1);
		apb(1, 12'h00c, 32'ha5);
		i = 0;
		while (rxs !== 1'b1 && i < 20) begin
			@(posedge pclk);
			i++;
		end
		chk(rxb, 8'ha5);
		mode <= 2'h1;
		repeat (4) @(posedge pclk);
		chk(oe_n, 1);
		chk(term, 0);
		apb(1, 12'h00c, 32'h3c);
		repeat (4) @(posedge pclk);
		chk(rxb, 8'ha5);
		apb(1, 12'h000, 32'h0);
		$display("receive done");
		txrun(20, 2'h0);
		txrun(3, 2'h2);
		stop_test();
	end
	initial begin
		#4000000;
		err_total++;
		stop_test();
	end
endmodule : usb_phy_parallel_link_port_tb
